// >>> src/pic_regs.vh
// Register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

// Register offsets (byte addresses on the 8-bit register port)
`define PIC_POSTED0_ADDR   8'hDA
`define PIC_MASK0_ADDR     8'hE0
`define PIC_SWCTL_ADDR     8'hE1
`define PIC_GCTL_ADDR      8'hE2
`define PIC_STATUS_ADDR    8'hE3

// Reset values
`define PIC_POSTED0_RST    8'h00
`define PIC_MASK0_RST      8'h00
`define PIC_SWCTL_RST      8'h00
`define PIC_GCTL_RST       8'h00
`define PIC_GIE_RST        1'b0

// Field positions
`define PIC_SWCTL_EN_BIT   0
`define PIC_GCTL_GIE_BIT   0

// Entry sequence length in CPU clock cycles
`define PIC_ENTRY_CYCLES   4'hD
// Return sequence start count: three pops, then the PC load
`define PIC_RETURN_FROM_INTERRUPT_INSTR_CYCLES    4'h4

// Vector table: vector equals four times the priority number
`define PIC_VEC_STRIDE     4
`define PIC_FIRST_PRIO     1

`endif

// >>> src/pic_ctrl.v
// Prioritized interrupt controller with entry and return sequencer
// Entry, counted from the edge that takes the interrupt (13 down to 1):
//   13  push PC high byte
//   12  push PC low byte
//   11  push the flags image, drop the global enable
//   2   fetch the vector, clear its posted bit, load PC
//   1   release the core
// The core only offers a boundary while no sequence runs, so a take
// always starts from a finished instruction.
//
// Return, counted from the edge that sees the return start (4 down to 0):
//   4..2  pop requests, one per cycle
//   2     flags byte arrives, global enable restored
//   1     PC low byte arrives and is held
//   0     PC high byte arrives, PC loaded, back to idle
// Stack data trails each pop request by one cycle, hence the two-edge
// gap between a request and the capture of its byte.
//
// Limitation: a take wins over a return offered in the same cycle; the
// core never issues both, since the enable is low inside a handler.
//
// Vectors are four times the priority number, upper PC byte zero.
// Bits 6 and 7 of the posted register are sleep and I2C, but I2C ranks
// higher, so the encoder does not simply pick the lowest bit.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pic_regs.vh"

module pic_ctrl #(
  parameter NSRC = 8
) (
  // Clock and reset
  input  wire              ref_clk,
  input  wire              rst,
  // Register port
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  // Interrupt sources, bit 0 supply monitor .. bit 7 I2C
  input  wire [NSRC-1:0]   src_event,
  // Core handshake
  input  wire              instr_done,
  input  wire              return_from_interrupt_instr_start,
  input  wire [7:0]        pc_high_byte,
  input  wire [7:0]        pc_low_byte,
  input  wire [7:0]        pop_data,
  output reg               entry_busy_ff,
  output reg               return_from_interrupt_instr_busy_ff,
  output reg               push_valid_ff,
  output reg  [7:0]        push_data_ff,
  output reg               pop_req_ff,
  output reg               pc_load_ff,
  output reg  [15:0]       pc_value_ff,
  output reg               global_irq_enable_ff,
  output reg               irq_active_ff
);

  // Sequencer states
  localparam ST_IDLE  = 2'd0;
  localparam ST_ENTRY = 2'd1;
  localparam ST_RETURN_FROM_INTERRUPT_INSTR  = 2'd2;

  reg  [1:0]      state_ff;
  reg  [3:0]      cnt_ff;
  reg  [7:0]      posted_ff;
  reg  [7:0]      mask_ff;
  reg             soft_irq_enable_ff;
  reg  [7:0]      vec_ff;
  reg  [2:0]      src_idx_ff;
  reg  [7:0]      flags_ff;
  reg  [7:0]      pcl_pop_ff;
  reg  [7:0]      sync1_ff;
  reg  [7:0]      sync2_ff;
  reg  [7:0]      sync3_ff;

  wire [7:0]      src_sync;
  wire [7:0]      src_rise;
  wire [7:0]      pending;
  wire [2:0]      win_idx;
  wire            win_any;
  wire            take;
  wire            wr_posted;
  wire            vec_fetch;
  wire [7:0]      nxt_posted;
  wire [3:0]      enc;

  // Priority number of a posted bit. Bits 0..5 follow their position;
  // the sleep bit (6) ranks below the I2C bit (7), so the two swap.
  function [4:0] prio_of;
    input [2:0] idx;
    begin
      case (idx)
        3'h6:    prio_of = 5'h08;
        3'h7:    prio_of = 5'h07;
        default: prio_of = {2'b00, idx} + 5'h01;
      endcase
    end
  endfunction

  // Priority encode: lowest priority number wins; bit 3 flags a winner
  function [3:0] prio_enc;
    input [7:0] p;
    integer k;
    reg [4:0] best;
    begin
      prio_enc = 4'h0;
      best     = 5'h1F;
      for (k = 0; k < 8; k = k + 1) begin
        if (p[k] && (prio_of(k[2:0]) < best)) begin
          best     = prio_of(k[2:0]);
          prio_enc = {1'b1, k[2:0]};
        end
      end
    end
  endfunction

  // Address compare shared by every register write decode
  function addr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      addr_hit = (a == target);
    end
  endfunction

  // Sources may come from blocks on other clocks or from pins, so each
  // passes two flops; a third flop remembers the old level for edge
  // detection. Cost: posting shows three cycles after the source rises.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      sync3_ff <= 8'h00;
    end else begin
      sync1_ff <= src_event[7:0];
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign src_sync = sync2_ff;
  assign src_rise = src_sync & ~sync3_ff;

  // Pending is posted and masked; mask leaves posting alone
  assign pending = posted_ff & mask_ff;
  assign enc     = prio_enc(pending);
  assign win_any = enc[3];
  assign win_idx = enc[2:0];

  // Take only at an instruction boundary with global enable set.
  // The highest-ranked pending interrupt left behind by a return is taken at the first
  // boundary after it, before the next normal instruction runs.
  assign take = (state_ff == ST_IDLE) && instr_done && win_any
                && global_irq_enable_ff;

  assign wr_posted = reg_wr && addr_hit(reg_addr, `PIC_POSTED0_ADDR);
  // The vector is fetched at count 2, the cycle that loads PC; the
  // posted bit of that source clears there, not at the take, so a
  // software read in between still shows it posted.
  assign vec_fetch = (state_ff == ST_ENTRY) && (cnt_ff == 4'd2);

  // Posted flags, one flop input per source. Hardware posting is ORed in
  // last, so an event lands even when software or a vector fetch clears
  // the same bit in that cycle; losing an event is worse than a repeat.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_post
      wire soft_set;
      wire soft_clr;
      wire fetch_clr;
      // Soft enable set: ones post, zeros do nothing
      assign soft_set  = wr_posted && soft_irq_enable_ff && reg_wdata[gi];
      // Soft enable clear: zeros clear, ones do nothing
      assign soft_clr  = wr_posted && !soft_irq_enable_ff && !reg_wdata[gi];
      // Only the source whose vector is fetched loses its flag
      assign fetch_clr = vec_fetch && (src_idx_ff == gi);
      assign nxt_posted[gi] = src_rise[gi] | soft_set
                              | (posted_ff[gi] & ~soft_clr & ~fetch_clr);
    end
  endgenerate

  // Mask and soft enable are plain software bits. Setting a mask bit
  // leaves the posted flag alone, so an event that arrived while masked
  // is taken, once the mask opens, at the first enabled boundary where no higher-ranked source is pending; software that does not want it
  // must clear the posted bit first.
  // Register state and posted flags
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      posted_ff          <= `PIC_POSTED0_RST;
      mask_ff            <= `PIC_MASK0_RST;
      soft_irq_enable_ff <= 1'b0;
    end else begin
      posted_ff <= nxt_posted;
      if (reg_wr && addr_hit(reg_addr, `PIC_MASK0_ADDR)) begin
        mask_ff <= reg_wdata;
      end
      if (reg_wr && addr_hit(reg_addr, `PIC_SWCTL_ADDR)) begin
        soft_irq_enable_ff <= reg_wdata[`PIC_SWCTL_EN_BIT];
      end
    end
  end

  // Register map of this block:
  //   DA  posted flags, read back, write clears or posts per soft enable
  //   E0  source mask, one bit per source
  //   E1  soft enable, bit 0
  //   E2  global enable, bit 0, ignored while a sequence runs
  //   E3  pending status, read only
  // Reads of any other address return zero so a stray probe is harmless.
  // Read data one cycle after the strobe; unmapped reads as zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PIC_POSTED0_ADDR: reg_rdata <= posted_ff;
        `PIC_MASK0_ADDR:   reg_rdata <= mask_ff;
        `PIC_SWCTL_ADDR:   reg_rdata <= {7'h00, soft_irq_enable_ff};
        `PIC_GCTL_ADDR:    reg_rdata <= {7'h00, global_irq_enable_ff};
        `PIC_STATUS_ADDR:  reg_rdata <= pending;
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Status flops: flags image for the push and the active indication.
  // The flags image lags the enable by one cycle, which is what the
  // push at count 11 needs: it still shows the enable before the drop.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_ff      <= 8'h00;
      irq_active_ff <= 1'b0;
    end else begin
      flags_ff      <= {7'h00, global_irq_enable_ff};
      irq_active_ff <= win_any && global_irq_enable_ff;
    end
  end

  // Entry and return sequencer; counter runs down from 13 or 4.
  // The push, pop and PC load strobes are registered pulses, cleared by default each cycle and
  // raised only in the count that owns them; a glitch-free handshake
  // matters more than one cycle of latency.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff             <= ST_IDLE;
      cnt_ff               <= 4'd0;
      vec_ff               <= 8'h00;
      src_idx_ff           <= 3'd0;
      pcl_pop_ff           <= 8'h00;
      entry_busy_ff        <= 1'b0;
      return_from_interrupt_instr_busy_ff         <= 1'b0;
      push_valid_ff        <= 1'b0;
      push_data_ff         <= 8'h00;
      pop_req_ff           <= 1'b0;
      pc_load_ff           <= 1'b0;
      pc_value_ff          <= 16'h0000;
      global_irq_enable_ff <= `PIC_GIE_RST;
    end else begin
      push_valid_ff <= 1'b0;
      pop_req_ff    <= 1'b0;
      pc_load_ff    <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          // Software sets or clears the global enable directly
          if (reg_wr && addr_hit(reg_addr, `PIC_GCTL_ADDR)) begin
            global_irq_enable_ff <= reg_wdata[`PIC_GCTL_GIE_BIT];
          end
          if (take) begin
            state_ff      <= ST_ENTRY;
            cnt_ff        <= `PIC_ENTRY_CYCLES;
            entry_busy_ff <= 1'b1;
            src_idx_ff    <= win_idx;
            vec_ff        <= {1'b0, prio_of(win_idx), 2'b00};
          end else if (return_from_interrupt_instr_start) begin
            state_ff     <= ST_RETURN_FROM_INTERRUPT_INSTR;
            cnt_ff       <= `PIC_RETURN_FROM_INTERRUPT_INSTR_CYCLES;
            return_from_interrupt_instr_busy_ff <= 1'b1;
          end
        end
        ST_ENTRY: begin
          cnt_ff <= cnt_ff - 4'd1;
          case (cnt_ff)
            // First push: return address, high byte
            4'd13: begin
              push_valid_ff <= 1'b1;
              push_data_ff  <= pc_high_byte;
            end
            // Second push: return address, low byte
            4'd12: begin
              push_valid_ff <= 1'b1;
              push_data_ff  <= pc_low_byte;
            end
            // Third push carries the old enable; the enable drops with it
            4'd11: begin
              push_valid_ff        <= 1'b1;
              push_data_ff         <= flags_ff;
              global_irq_enable_ff <= 1'b0;
            end
            // Vector goes to PC low, PC high forced to zero
            4'd2: begin
              pc_value_ff <= {8'h00, vec_ff};
              pc_load_ff  <= 1'b1;
            end
            // Hand the core back
            4'd1: begin
              state_ff      <= ST_IDLE;
              entry_busy_ff <= 1'b0;
            end
            default: begin
              cnt_ff <= cnt_ff - 4'd1;
            end
          endcase
        end
        ST_RETURN_FROM_INTERRUPT_INSTR: begin
          cnt_ff     <= cnt_ff - 4'd1;
          // One pop per cycle at counts 4, 3 and 2
          pop_req_ff <= (cnt_ff >= 4'd2);
          case (cnt_ff)
            // Flags byte: restores the global enable
            4'd2: begin
              global_irq_enable_ff <= pop_data[`PIC_GCTL_GIE_BIT];
            end
            // PC low byte, held until the high byte arrives
            4'd1: begin
              pcl_pop_ff <= pop_data;
            end
            // PC high byte: load the full return address
            4'd0: begin
              pc_value_ff  <= {pop_data, pcl_pop_ff};
              pc_load_ff   <= 1'b1;
              state_ff     <= ST_IDLE;
              return_from_interrupt_instr_busy_ff <= 1'b0;
            end
            default: begin
              cnt_ff <= cnt_ff - 4'd1;
            end
          endcase
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // pic_ctrl
`default_nettype wire

// >>> verification/pic_core_model.sv
// Behavioural core facing the controller: boundaries, stack, return start
`timescale 1ns/1ns
`default_nettype none
module pic_core_model (
  // Clock, reset and bench command
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       do_return_from_interrupt_instr,
  // Controller outputs
  input  wire logic       entry_busy_ff,
  input  wire logic       return_from_interrupt_instr_busy_ff,
  input  wire logic       push_valid_ff,
  input  wire logic [7:0] push_data_ff,
  input  wire logic       pop_req_ff,
  // Core outputs
  output var  logic       instr_done,
  output var  logic       return_from_interrupt_instr_start,
  output var  logic [7:0] pc_high_byte,
  output var  logic [7:0] pc_low_byte,
  output var  logic [7:0] pop_data
);
  logic [7:0] stk[$];
  logic [1:0] cnt;
  // Fixed return address, easy to spot after a return
  assign pc_high_byte = 8'h12;
  assign pc_low_byte  = 8'h34;
  // Boundary every fourth cycle; none while a sequence owns the core
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 2'h0;
      instr_done <= 1'b0;
      return_from_interrupt_instr_start <= 1'b0;
      pop_data <= 8'h00;
    end else begin
      cnt <= cnt + 2'h1;
      instr_done <= (cnt == 2'h3) && !entry_busy_ff && !return_from_interrupt_instr_busy_ff;
      return_from_interrupt_instr_start <= do_return_from_interrupt_instr;
      if (push_valid_ff) stk.push_back(push_data_ff);
      // Stale stack data is inverted so it never passes for a pop
      if (pop_req_ff) pop_data <= stk.pop_back();
      else pop_data <= ~pop_data;
    end
  end
endmodule // pic_core_model
`default_nettype wire

// >>> verification/pic_ctrl_checker.sv
// Port assertions for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl_checker (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Register port
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Core handshake
  input wire logic        instr_done,
  input wire logic        entry_busy_ff,
  input wire logic        return_from_interrupt_instr_busy_ff,
  input wire logic        push_valid_ff,
  input wire logic        pop_req_ff,
  input wire logic        pc_load_ff,
  input wire logic [15:0] pc_value_ff,
  input wire logic        global_irq_enable_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_len;
    $rose(entry_busy_ff) |=> entry_busy_ff[*8] ##1 entry_busy_ff[*4] ##1 !entry_busy_ff;
  endproperty
  property p_start;
    $rose(entry_busy_ff) |-> $past(instr_done) && $past(global_irq_enable_ff);
  endproperty
  property p_vec;
    pc_load_ff && entry_busy_ff |-> pc_value_ff[15:8] == 8'h00 && pc_value_ff[1:0] == 2'h0
      && pc_value_ff[7:0] != 8'h00 && !global_irq_enable_ff;
  endproperty
  property p_load;
    $rose(entry_busy_ff) |-> ##[1:12] pc_load_ff;
  endproperty
  property p_push3;
    $rose(entry_busy_ff) |-> ##[0:3] push_valid_ff[*3];
  endproperty
  property p_push;
    push_valid_ff |-> entry_busy_ff;
  endproperty
  property p_gie;
    $rose(entry_busy_ff) |-> ##[1:4] !global_irq_enable_ff;
  endproperty
  property p_pop;
    pop_req_ff |-> return_from_interrupt_instr_busy_ff && !entry_busy_ff;
  endproperty
  property p_rdata;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_len: assert property (p_len) else $error("entry length wrong");
  a_start: assert property (p_start) else $error("entry without cause");
  a_vec: assert property (p_vec) else $error("bad entry load");
  a_load: assert property (p_load) else $error("no vector load");
  a_push3: assert property (p_push3) else $error("pushes missing");
  a_push: assert property (p_push) else $error("push outside entry");
  a_gie: assert property (p_gie) else $error("enable kept");
  a_pop: assert property (p_pop) else $error("pop outside return");
  a_rdata: assert property (p_rdata) else $error("stray read data");
  // Main scenarios reached
  c_entry: cover property ($rose(entry_busy_ff));
  c_return_from_interrupt_instr: cover property ($rose(return_from_interrupt_instr_busy_ff));
  c_reload: cover property (pc_load_ff && $fell(return_from_interrupt_instr_busy_ff));
endmodule // pic_ctrl_checker
bind pic_ctrl pic_ctrl_checker i_pic_ctrl_checker (.ref_clk, .rst, .reg_rd, .reg_rdata,
  .instr_done, .entry_busy_ff, .return_from_interrupt_instr_busy_ff, .push_valid_ff, .pop_req_ff, .pc_load_ff,
  .pc_value_ff, .global_irq_enable_ff);
`default_nettype wire

// >>> verification/pic_ctrl_test.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "pic_regs.vh"
module pic_ctrl_test;
  localparam logic [7:0] PST = `PIC_POSTED0_ADDR;
  localparam logic [7:0] SWC = `PIC_SWCTL_ADDR;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, do_return_from_interrupt_instr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, src_event = 8'h00;
  logic [7:0] reg_rdata, push_data_ff, pc_high_byte, pc_low_byte, pop_data;
  logic instr_done, return_from_interrupt_instr_start, entry_busy_ff, return_from_interrupt_instr_busy_ff, push_valid_ff, pop_req_ff;
  logic pc_load_ff, global_irq_enable_ff, irq_active_ff;
  logic [15:0] pc_value_ff;
  int mismatches = 0;
  int checks = 0;
  pic_ctrl i_pic_ctrl (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .src_event, .instr_done, .return_from_interrupt_instr_start, .pc_high_byte, .pc_low_byte, .pop_data,
    .entry_busy_ff, .return_from_interrupt_instr_busy_ff, .push_valid_ff, .push_data_ff, .pop_req_ff, .pc_load_ff,
    .pc_value_ff, .global_irq_enable_ff, .irq_active_ff);
  pic_core_model i_pic_core_model (.ref_clk, .rst, .do_return_from_interrupt_instr, .entry_busy_ff, .return_from_interrupt_instr_busy_ff,
    .push_valid_ff, .push_data_ff, .pop_req_ff, .instr_done, .return_from_interrupt_instr_start, .pc_high_byte,
    .pc_low_byte, .pop_data);
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("read data", {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // Bounded wait for a program counter load
  task automatic wait_load(input logic [15:0] exp);
    int n = 0;
    while (pc_load_ff !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("pc load", pc_value_ff, exp);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run is under a thousand cycles; the watchdog allows ten times that
  initial begin
    #40000 mismatches++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(PST, `PIC_POSTED0_RST);
    rd(`PIC_MASK0_ADDR, `PIC_MASK0_RST);
    rd(8'h10, 8'h00);
    wr(SWC, 8'h01);
    wr(PST, 8'h5A);
    rd(PST, 8'h5A);
    wr(PST, 8'h00);
    rd(PST, 8'h5A);
    wr(SWC, 8'h00);
    wr(PST, 8'hFF);
    rd(PST, 8'h5A);
    wr(PST, 8'hF7);
    rd(PST, 8'h52);
    wr(PST, 8'h00);
    // GPIO event posts while masked and stays posted
    src_event <= 8'h10;
    repeat (5) @(posedge ref_clk);
    src_event <= 8'h00;
    rd(PST, 8'h10);
    chk("active masked", irq_active_ff, 16'h0);
    wr(`PIC_MASK0_ADDR, 8'h10);
    rd(`PIC_STATUS_ADDR, 8'h10);
    repeat (3) @(posedge ref_clk);
    #1 chk("active no enable", irq_active_ff, 16'h0);
    chk("no entry", entry_busy_ff, 16'h0);
    wr(`PIC_GCTL_ADDR, 8'h01);
    @(posedge ref_clk);
    #1 chk("active", irq_active_ff, 16'h1);
    wait_load(16'h0014);
    chk("stack depth", i_pic_core_model.stk.size(), 16'h3);
    chk("push pch", i_pic_core_model.stk[0], 16'h12);
    chk("push pcl", i_pic_core_model.stk[1], 16'h34);
    chk("push flags", i_pic_core_model.stk[2], 16'h01);
    chk("gie", global_irq_enable_ff, 16'h0);
    rd(PST, 8'h00);
    // Three sources posted by software while in the handler
    wr(SWC, 8'h01);
    wr(PST, 8'hC4);
    wr(`PIC_MASK0_ADDR, 8'hFF);
    chk("held", entry_busy_ff, 16'h0);
    do_return_from_interrupt_instr <= 1'b1;
    @(posedge ref_clk);
    do_return_from_interrupt_instr <= 1'b0;
    wait_load(16'h1234);
    wait_load(16'h000C);
    rd(PST, 8'hC0);
    @(posedge ref_clk);
    do_return_from_interrupt_instr <= 1'b1;
    @(posedge ref_clk);
    do_return_from_interrupt_instr <= 1'b0;
    wait_load(16'h1234);
    wait_load(16'h001C);
    rd(PST, 8'h40);
    @(posedge ref_clk);
    do_return_from_interrupt_instr <= 1'b1;
    @(posedge ref_clk);
    do_return_from_interrupt_instr <= 1'b0;
    wait_load(16'h1234);
    wait_load(16'h0020);
    conclude();
  end
endmodule // pic_ctrl_test
`default_nettype wire
